// *** common/cpm_pkg.sv ***
// Shared constants and types for the clock and power mode controller.
package cpm_pkg;

  // Core clock rate in kHz; oscillator rates are produced as tick pulses.
  localparam int unsigned CORE_CLK_KHZ = 250000;
  localparam logic [17:0] CORE_CLK_KHZ_W = 18'h3d090;

  // Fast oscillator and low-power oscillator rates in kHz.
  localparam logic [17:0] FRO_15_KHZ = 18'h03a98;
  localparam logic [17:0] FRO_12_KHZ = 18'h02ee0;
  localparam logic [17:0] FRO_9_KHZ = 18'h02328;
  localparam logic [17:0] LPOSC_KHZ = 18'h003e8;

  // Fast oscillator frequency select encodings.
  localparam logic [1:0] FRO_SEL_12 = 2'h0;
  localparam logic [1:0] FRO_SEL_15 = 2'h1;
  localparam logic [1:0] FRO_SEL_9 = 2'h2;
  localparam logic [1:0] FRO_SEL_RST = FRO_SEL_12;

  // Main clock source encodings; NONE is the tied-off input.
  localparam logic [2:0] MAIN_SEL_FRO = 3'h0;
  localparam logic [2:0] MAIN_SEL_FRO_DIV = 3'h1;
  localparam logic [2:0] MAIN_SEL_EXT = 3'h2;
  localparam logic [2:0] MAIN_SEL_LPOSC = 3'h3;
  localparam logic [2:0] MAIN_SEL_NONE = 3'h7;
  localparam logic [2:0] MAIN_SEL_RST = MAIN_SEL_FRO;

  // Clock output source encodings; NONE is the tied-off input.
  localparam logic [2:0] CLOCK_OUTPUT_FUNCTION_SEL_FRO = 3'h0;
  localparam logic [2:0] CLOCK_OUTPUT_FUNCTION_SEL_LPOSC = 3'h1;
  localparam logic [2:0] CLOCK_OUTPUT_FUNCTION_SEL_EXT = 3'h2;
  localparam logic [2:0] CLOCK_OUTPUT_FUNCTION_SEL_MAIN = 3'h3;
  localparam logic [2:0] CLOCK_OUTPUT_FUNCTION_SEL_NONE = 3'h7;
  localparam logic [2:0] CLOCK_OUTPUT_FUNCTION_SEL_RST = CLOCK_OUTPUT_FUNCTION_SEL_NONE;

  // Core clock divider; zero and one both mean undivided.
  localparam logic [7:0] CORE_DIV_RST = 8'h01;

  // Reduced power mode requests.
  localparam logic [1:0] REQ_SLEEP = 2'h1;
  localparam logic [1:0] REQ_DEEP = 2'h2;
  localparam logic [1:0] REQ_PDOWN = 2'h3;

  // Peripheral gates and wake sources.
  localparam int unsigned NUM_PERIPH = 8;
  localparam logic [7:0] PERIPH_GATE_RST = 8'h00;
  localparam int unsigned NUM_WAKE = 6;

  // Power mode state machine.
  typedef enum logic [2:0] {
    CPM_RUN   = 3'b000,
    CPM_SLEEP = 3'b001,
    CPM_DEEP  = 3'b010,
    CPM_PDOWN = 3'b011,
    CPM_WAKE  = 3'b100
  } cpm_mode_t;

endpackage

// *** core/cpm_rate_gen.sv ***
// Fractional tick generator that models an oscillator as enable pulses.
`timescale 1ns/1ps
module cpm_rate_gen (
  // Clock and reset.
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  // Oscillator control.
  input  wire logic        i_enable,
  input  wire logic [17:0] i_step_khz,
  // Oscillator tick.
  output logic             o_tick
);

  typedef struct packed {
    logic [17:0] acc;
    logic        tick;
  } cpm_rg_state_t;

  cpm_rg_state_t s_q;
  cpm_rg_state_t s_d;
  logic [18:0]   sum;

  // Phase accumulator wraps at the core rate; jitter is one core cycle.
  always_comb begin
    s_d = s_q;
    sum = {1'b0, s_q.acc} + {1'b0, i_step_khz};
    s_d.tick = 1'b0;
    if (!i_enable) begin
      s_d.acc = 18'h00000;
    end else if (sum >= {1'b0, cpm_pkg::CORE_CLK_KHZ_W}) begin
      s_d.acc = 18'(sum - {1'b0, cpm_pkg::CORE_CLK_KHZ_W});
      s_d.tick = 1'b1;
    end else begin
      s_d.acc = sum[17:0];
    end
  end

  // State register.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_tick = s_q.tick;

endmodule

// *** core/cpm_pin_sync.sv ***
// Three-flop pin synchroniser with a rising-edge tick.
`timescale 1ns/1ps
module cpm_pin_sync (
  // Clock and reset.
  input  wire logic i_core_clk,
  input  wire logic i_rst,
  // Asynchronous pin.
  input  wire logic i_pin,
  // Rising edge, one cycle.
  output logic      o_rise
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic rise;
  } cpm_ps_state_t;

  cpm_ps_state_t s_q;
  cpm_ps_state_t s_d;

  // The level moves only when the second and third stages agree.
  always_comb begin
    s_d = s_q;
    s_d.s1 = i_pin;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    s_d.rise = 1'b0;
    if (s_q.s2 == s_q.s3) begin
      s_d.level = s_q.s3;
      s_d.rise = s_q.s3 & ~s_q.level;
    end
  end

  // State register.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_rise = s_q.rise;

endmodule

// *** core/cpm_top.sv ***
// Clock generation and power mode control as clock-enable ticks.
//
// How it works
// - After reset the main clock is the fast oscillator until changed.
// - Fast oscillator frequency selectable as 15, 12 or 9 MHz.
// - Halved fast oscillator (7.5, 6, 4.5 MHz) selectable as main clock.
// - Fast oscillator resets to 12 MHz.
// - A 1 MHz low-power oscillator may serve as main clock.
// - Low-power oscillator ticks only while its run enable bit is set.
// - Main and output multiplexers have a tied-off input to save power.
// - Main clock feeds the core, the bus and peripheral clocks.
// - Clock output selects any oscillator or the main clock.
// - Core rate set by main source and a core divider value.
// - Each peripheral has its own clock gate.
// - Sleep stops only the core clock; wake just restarts it.
// - Sleep lasts until reset or interrupt; peripherals keep running.
// - Deep-sleep stops clocks except a kept fast or low-power oscillator.
// - Deep-sleep gates fast oscillator output, analog off, flash standby.
// - Deep-sleep ends on reset, pin, watchdog, touch, slave serial irqs.
// - Wake needs both the wake enable and the interrupt controller enable.
// - Power-down runs only a kept low-power oscillator; analog, flash off.
// - Power-down uses the same wake sources as deep-sleep.
// - Low-power oscillator and brownout detector may run in deep modes.
`timescale 1ns/1ps
module cpm_top (
  // Clock and reset.
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  // Clock configuration, loaded on the write strobe while running.
  input  wire logic        i_clk_cfg_wr,
  input  wire logic [1:0]  i_fro_freq_sel,
  input  wire logic [2:0]  i_main_sel,
  input  wire logic [2:0]  i_clock_output_function_sel,
  input  wire logic [7:0]  i_core_div,
  input  wire logic [7:0]  i_periph_gate,
  // Run power configuration and low-power keep options.
  input  wire logic        i_lposc_en,
  input  wire logic        i_lposc_keep,
  input  wire logic        i_fro_keep_deep,
  input  wire logic        i_bod_keep,
  // Power mode entry from the core.
  input  wire logic        i_mode_enter,
  input  wire logic [1:0]  i_mode_req,
  // Interrupts and wake sources.
  input  wire logic        i_any_irq,
  input  wire logic [5:0]  i_wake_irq,
  input  wire logic [5:0]  i_wake_en,
  input  wire logic [5:0]  i_irq_en,
  // External clock pin.
  input  wire logic        i_ext_clock_pin,
  // Clock enables out.
  output logic             o_main_clk_en,
  output logic             o_core_clk_en,
  output logic [7:0]       o_periph_clk_en,
  output logic             o_clock_output_function_en,
  output logic             o_lposc_clk_en,
  // Power controls and status.
  output logic             o_fro_run,
  output logic             o_fro_out_en,
  output logic             o_lposc_run,
  output logic             o_analog_pd,
  output logic             o_flash_standby,
  output logic             o_flash_off,
  output logic             o_bod_run,
  output logic [2:0]       o_mode,
  output logic             o_wake
);

  typedef struct packed {
    cpm_pkg::cpm_mode_t mode;
    logic [1:0]         fro_sel;
    logic [2:0]         main_sel;
    logic [2:0]         clock_output_function_sel;
    logic [7:0]         core_div;
    logic [7:0]         gate;
    logic [7:0]         div_cnt;
    logic               half_ph;
    logic               main_en;
    logic               core_en;
    logic [7:0]         periph_en;
    logic               clock_output_function_en;
    logic               lposc_clk;
    logic               fro_run;
    logic               fro_out;
    logic               lposc_run;
    logic               analog_pd;
    logic               flash_sb;
    logic               flash_off;
    logic               bod_run;
    logic               wake;
  } cpm_state_t;

  cpm_state_t  s_q;
  cpm_state_t  s_d;
  logic [17:0] fro_step;
  logic        fro_tick;
  logic        lposc_tick;
  logic        ext_tick;
  logic        fro_deliv;
  logic        half_deliv;
  logic        ext_deliv;
  logic        main_tick;
  logic        low_power;
  logic        wake_hit;
  logic        core_tick;

  // Fast oscillator step from the held frequency selection.
  always_comb begin
    case (s_q.fro_sel)
      cpm_pkg::FRO_SEL_15: fro_step = cpm_pkg::FRO_15_KHZ;
      cpm_pkg::FRO_SEL_9:  fro_step = cpm_pkg::FRO_9_KHZ;
      default:             fro_step = cpm_pkg::FRO_12_KHZ;
    endcase
  end

  // Fast oscillator runs from its registered run control.
  cpm_rate_gen u_fro (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_enable   (s_q.fro_run),
    .i_step_khz (fro_step),
    .o_tick     (fro_tick)
  );

  // Low-power oscillator only ticks when enabled and allowed by the mode.
  cpm_rate_gen u_lposc (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_enable   (s_q.lposc_run),
    .i_step_khz (cpm_pkg::LPOSC_KHZ),
    .o_tick     (lposc_tick)
  );

  // The external clock is resolved only well below the core rate, which
  // holds while the far side keeps it at or below 15 MHz.
  cpm_pin_sync u_ext (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_pin      (i_ext_clock_pin),
    .o_rise     (ext_tick)
  );

  // Source delivery; deep modes block fast oscillator and pin clocks.
  assign low_power  = (s_q.mode == cpm_pkg::CPM_DEEP) ||
                      (s_q.mode == cpm_pkg::CPM_PDOWN);
  assign fro_deliv  = fro_tick & s_q.fro_out;
  assign half_deliv = fro_deliv & s_q.half_ph;
  assign ext_deliv  = ext_tick & ~low_power;

  // Main clock multiplexer; the tied-off input never ticks.
  always_comb begin
    case (s_q.main_sel)
      cpm_pkg::MAIN_SEL_FRO:     main_tick = fro_deliv;
      cpm_pkg::MAIN_SEL_FRO_DIV: main_tick = half_deliv;
      cpm_pkg::MAIN_SEL_EXT:     main_tick = ext_deliv;
      cpm_pkg::MAIN_SEL_LPOSC:   main_tick = lposc_tick;
      default:                   main_tick = 1'b0;
    endcase
  end

  // Core divider counts main ticks; a divider of zero acts as one.
  assign core_tick = main_tick &&
                     ((s_q.core_div <= 8'h01) ||
                      (s_q.div_cnt >= 8'(s_q.core_div - 8'h01)));

  // Any enabled wake source ends deep-sleep and power-down.
  assign wake_hit = |(i_wake_irq & i_wake_en & i_irq_en);

  // Next-state logic for mode, configuration and every output.
  always_comb begin
    s_d = s_q;
    s_d.wake = 1'b0;

    // Configuration is only taken while running, so what was selected
    // before a low-power entry is still held on wake.
    if (i_clk_cfg_wr && s_q.mode == cpm_pkg::CPM_RUN) begin
      s_d.fro_sel    = i_fro_freq_sel;
      s_d.main_sel   = i_main_sel;
      s_d.clock_output_function_sel = i_clock_output_function_sel;
      s_d.core_div   = i_core_div;
      s_d.gate       = i_periph_gate;
    end

    // Half-rate phase follows delivered fast oscillator ticks.
    if (fro_deliv) begin
      s_d.half_ph = ~s_q.half_ph;
    end

    // Divider counter advances on main ticks and restarts on a core tick.
    if (core_tick) begin
      s_d.div_cnt = 8'h00;
    end else if (main_tick) begin
      s_d.div_cnt = 8'(s_q.div_cnt + 8'h01);
    end

    // Power mode sequencing.
    case (s_q.mode)
      cpm_pkg::CPM_RUN: begin
        if (i_mode_enter) begin
          case (i_mode_req)
            cpm_pkg::REQ_SLEEP: s_d.mode = cpm_pkg::CPM_SLEEP;
            cpm_pkg::REQ_DEEP:  s_d.mode = cpm_pkg::CPM_DEEP;
            cpm_pkg::REQ_PDOWN: s_d.mode = cpm_pkg::CPM_PDOWN;
            default:            s_d.mode = cpm_pkg::CPM_RUN;
          endcase
        end
      end
      cpm_pkg::CPM_SLEEP: begin
        if (i_any_irq) begin
          s_d.mode = cpm_pkg::CPM_RUN;
          s_d.wake = 1'b1;
        end
      end
      cpm_pkg::CPM_DEEP: begin
        if (wake_hit) begin
          s_d.mode = cpm_pkg::CPM_WAKE;
        end
      end
      cpm_pkg::CPM_PDOWN: begin
        if (wake_hit) begin
          s_d.mode = cpm_pkg::CPM_WAKE;
        end
      end
      cpm_pkg::CPM_WAKE: begin
        // Sources come back one cycle ahead of the core clock.
        s_d.mode = cpm_pkg::CPM_RUN;
        s_d.wake = 1'b1;
      end
      default: begin
        s_d.mode = cpm_pkg::CPM_RUN;
      end
    endcase

    // Oscillator and power controls follow the next mode.
    case (s_d.mode)
      cpm_pkg::CPM_DEEP: begin
        s_d.fro_run   = i_fro_keep_deep;
        s_d.fro_out   = 1'b0;
        s_d.lposc_run = i_lposc_en & i_lposc_keep;
        s_d.analog_pd = 1'b1;
        s_d.flash_sb  = 1'b1;
        s_d.flash_off = 1'b0;
        s_d.bod_run   = i_bod_keep;
      end
      cpm_pkg::CPM_PDOWN: begin
        s_d.fro_run   = 1'b0;
        s_d.fro_out   = 1'b0;
        s_d.lposc_run = i_lposc_en & i_lposc_keep;
        s_d.analog_pd = 1'b1;
        s_d.flash_sb  = 1'b0;
        s_d.flash_off = 1'b1;
        s_d.bod_run   = i_bod_keep;
      end
      default: begin
        // Run, sleep and wake restore every source to its selection.
        s_d.fro_run   = 1'b1;
        s_d.fro_out   = 1'b1;
        s_d.lposc_run = i_lposc_en;
        s_d.analog_pd = 1'b0;
        s_d.flash_sb  = 1'b0;
        s_d.flash_off = 1'b0;
        s_d.bod_run   = 1'b1;
      end
    endcase

    // Registered clock enables; the core stops outside run only.
    s_d.main_en = main_tick & ~low_power;
    s_d.core_en = core_tick && s_q.mode == cpm_pkg::CPM_RUN;
    s_d.lposc_clk = lposc_tick;
    for (int i = 0; i < cpm_pkg::NUM_PERIPH; i++) begin
      // Sleep keeps peripherals clocked; deep modes stop them all.
      s_d.periph_en[i] = main_tick & s_q.gate[i] & ~low_power;
    end

    // Clock output multiplexer with its own tied-off input.
    case (s_q.clock_output_function_sel)
      cpm_pkg::CLOCK_OUTPUT_FUNCTION_SEL_FRO:   s_d.clock_output_function_en = fro_deliv;
      cpm_pkg::CLOCK_OUTPUT_FUNCTION_SEL_LPOSC: s_d.clock_output_function_en = lposc_tick;
      cpm_pkg::CLOCK_OUTPUT_FUNCTION_SEL_EXT:   s_d.clock_output_function_en = ext_deliv;
      cpm_pkg::CLOCK_OUTPUT_FUNCTION_SEL_MAIN:  s_d.clock_output_function_en = main_tick & ~low_power;
      default:                   s_d.clock_output_function_en = 1'b0;
    endcase
  end

  // State register; reset returns to the fast oscillator at 12 MHz.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      s_q.mode       <= cpm_pkg::CPM_RUN;
      s_q.fro_sel    <= cpm_pkg::FRO_SEL_RST;
      s_q.main_sel   <= cpm_pkg::MAIN_SEL_RST;
      s_q.clock_output_function_sel <= cpm_pkg::CLOCK_OUTPUT_FUNCTION_SEL_RST;
      s_q.core_div   <= cpm_pkg::CORE_DIV_RST;
      s_q.gate       <= cpm_pkg::PERIPH_GATE_RST;
      s_q.div_cnt    <= 8'h00;
      s_q.half_ph    <= 1'b0;
      s_q.main_en    <= 1'b0;
      s_q.core_en    <= 1'b0;
      s_q.periph_en  <= 8'h00;
      s_q.clock_output_function_en  <= 1'b0;
      s_q.lposc_clk  <= 1'b0;
      s_q.fro_run    <= 1'b1;
      s_q.fro_out    <= 1'b1;
      s_q.lposc_run  <= 1'b0;
      s_q.analog_pd  <= 1'b0;
      s_q.flash_sb   <= 1'b0;
      s_q.flash_off  <= 1'b0;
      s_q.bod_run    <= 1'b1;
      s_q.wake       <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register.
  assign o_main_clk_en   = s_q.main_en;
  assign o_core_clk_en   = s_q.core_en;
  assign o_periph_clk_en = s_q.periph_en;
  assign o_clock_output_function_en     = s_q.clock_output_function_en;
  assign o_lposc_clk_en  = s_q.lposc_clk;
  assign o_fro_run       = s_q.fro_run;
  assign o_fro_out_en    = s_q.fro_out;
  assign o_lposc_run     = s_q.lposc_run;
  assign o_analog_pd     = s_q.analog_pd;
  assign o_flash_standby = s_q.flash_sb;
  assign o_flash_off     = s_q.flash_off;
  assign o_bod_run       = s_q.bod_run;
  assign o_mode          = s_q.mode;
  assign o_wake          = s_q.wake;

endmodule

// *** tb/cpm_top_properties.sv ***
// Checker of the power mode sequencing at the controller ports.
`timescale 1ns/1ps
module cpm_top_properties (
  // Clock and reset.
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  // Watched inputs.
  input  wire logic       i_lposc_en,
  input  wire logic       i_mode_enter,
  input  wire logic [1:0] i_mode_req,
  input  wire logic       i_any_irq,
  input  wire logic [5:0] i_wake_irq,
  input  wire logic [5:0] i_wake_en,
  input  wire logic [5:0] i_irq_en,
  // Watched outputs.
  input  wire logic       o_core_clk_en,
  input  wire logic [7:0] o_periph_clk_en,
  input  wire logic       o_lposc_clk_en,
  input  wire logic       o_fro_run,
  input  wire logic       o_fro_out_en,
  input  wire logic       o_analog_pd,
  input  wire logic       o_flash_standby,
  input  wire logic       o_flash_off,
  input  wire logic [2:0] o_mode,
  input  wire logic       o_wake
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // A wake counts only when both enables agree on one source.
  wire logic hit = |(i_wake_irq & i_wake_en & i_irq_en);
  wire logic low = (o_mode == 3'h2) || (o_mode == 3'h3);
  property p_reset_run;
    $fell(i_rst) |-> o_mode == 3'h0 && o_fro_run && o_fro_out_en;
  endproperty
  a_reset_run: assert property (p_reset_run)
    else $error("mode or fast oscillator wrong after reset");
  property p_enter;
    o_mode == 3'h0 && i_mode_enter && i_mode_req != 2'h0
      |=> o_mode == {1'b0, $past(i_mode_req)};
  endproperty
  a_enter: assert property (p_enter)
    else $error("mode request not taken");
  // The first cycle of a new mode may still carry a launched tick.
  property p_core_stop;
    o_mode != 3'h0 && $past(o_mode) != 3'h0 |-> !o_core_clk_en;
  endproperty
  a_core_stop: assert property (p_core_stop)
    else $error("core tick outside run");
  property p_sleep_exit;
    o_mode == 3'h1 && i_any_irq |=> o_mode == 3'h0 && o_wake;
  endproperty
  a_sleep_exit: assert property (p_sleep_exit)
    else $error("sleep did not end on interrupt");
  property p_deep_out;
    o_mode == 3'h2 |-> !o_fro_out_en && o_analog_pd && o_flash_standby;
  endproperty
  a_deep_out: assert property (p_deep_out)
    else $error("deep-sleep power controls wrong");
  property p_pdown_out;
    o_mode == 3'h3 |-> !o_fro_run && o_analog_pd && o_flash_off;
  endproperty
  a_pdown_out: assert property (p_pdown_out)
    else $error("power-down controls wrong");
  property p_periph_off;
    low && $past(low) |-> o_periph_clk_en == 8'h00;
  endproperty
  a_periph_off: assert property (p_periph_off)
    else $error("peripheral tick in deep mode");
  property p_wake_seq;
    low && hit |=> o_mode == 3'h4 ##1 (o_mode == 3'h0 && o_wake);
  endproperty
  a_wake_seq: assert property (p_wake_seq)
    else $error("wake sequence wrong");
  property p_masked;
    low && !hit |=> $stable(o_mode);
  endproperty
  a_masked: assert property (p_masked)
    else $error("woke without both enables");
  // Run enable, oscillator tick and output tick are three register stages.
  property p_lposc_off;
    (!i_lposc_en) [*4] |-> !o_lposc_clk_en;
  endproperty
  a_lposc_off: assert property (p_lposc_off)
    else $error("low-power tick while disabled");
endmodule
bind cpm_top cpm_top_properties i_props (.*);

// *** tb/cpm_clk_consumer.sv ***
// Model of the core, bus and peripherals that tally the enables they get.
`timescale 1ns/1ps
module cpm_clk_consumer (
  // Clock and window clear.
  input  wire logic        i_core_clk,
  input  wire logic        i_clear,
  // Enables from the controller.
  input  wire logic        i_main_en,
  input  wire logic        i_core_en,
  input  wire logic        i_out_en,
  input  wire logic        i_lp_en,
  input  wire logic [7:0]  i_periph_en,
  // Tallies over the window.
  output logic      [15:0] o_main_cnt,
  output logic      [15:0] o_core_cnt,
  output logic      [15:0] o_out_cnt,
  output logic      [15:0] o_lp_cnt,
  output logic      [7:0]  o_seen
);
  // Each consumer advances once per enable, so a tally is a mean rate.
  always_ff @(posedge i_core_clk) begin
    if (i_clear) begin
      o_main_cnt <= 16'h0000;
      o_core_cnt <= 16'h0000;
      o_out_cnt  <= 16'h0000;
      o_lp_cnt   <= 16'h0000;
      o_seen     <= 8'h00;
    end else begin
      o_main_cnt <= o_main_cnt + 16'(i_main_en);
      o_core_cnt <= o_core_cnt + 16'(i_core_en);
      o_out_cnt  <= o_out_cnt + 16'(i_out_en);
      o_lp_cnt   <= o_lp_cnt + 16'(i_lp_en);
      o_seen     <= o_seen | i_periph_en;
    end
  end
endmodule

// *** tb/cpm_top_tb.sv ***
// Self-checking bench for the clock and power mode controller.
`timescale 1ns/1ps
module cpm_top_tb;
  // Controller inputs, driven on the falling edge.
  logic        i_core_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        i_clk_cfg_wr = 1'b0, i_lposc_en = 1'b0, i_lposc_keep = 1'b0;
  logic        i_fro_keep_deep = 1'b1, i_bod_keep = 1'b0;
  logic        i_mode_enter = 1'b0, i_any_irq = 1'b0, i_ext_clock_pin = 1'b0;
  logic [1:0]  i_fro_freq_sel = 2'h0, i_mode_req = 2'h0;
  logic [2:0]  i_main_sel = 3'h0, i_clock_output_function_sel = 3'h7;
  logic [7:0]  i_core_div = 8'h01, i_periph_gate = 8'h00;
  logic [5:0]  i_wake_irq = 6'h00, i_wake_en = 6'h00, i_irq_en = 6'h00;
  // Controller outputs.
  logic        o_main_clk_en, o_core_clk_en, o_clock_output_function_en, o_lposc_clk_en;
  logic        o_fro_run, o_fro_out_en, o_lposc_run, o_analog_pd;
  logic        o_flash_standby, o_flash_off, o_bod_run, o_wake;
  logic [7:0]  o_periph_clk_en;
  logic [2:0]  o_mode;
  // Consumer tallies and bookkeeping.
  logic        clear = 1'b1;
  logic [15:0] main_cnt, core_cnt, out_cnt, lp_cnt;
  logic [7:0]  seen;
  int          err_count = 0;
  int          checks = 0;
  int          cycles = 0;
  wire  [5:0]  pw = {o_fro_run, o_fro_out_en, o_analog_pd, o_flash_off,
                     o_lposc_run, o_bod_run};
  // Core clock at 250 MHz.
  always #2 i_core_clk = ~i_core_clk;
  // External source at 12.5 MHz, inside the 15 MHz ceiling.
  always #40 i_ext_clock_pin = ~i_ext_clock_pin;
  cpm_top i_dut (.*);
  cpm_clk_consumer i_cons (
    .i_core_clk  (i_core_clk),
    .i_clear     (clear),
    .i_main_en   (o_main_clk_en),
    .i_core_en   (o_core_clk_en),
    .i_out_en    (o_clock_output_function_en),
    .i_lp_en     (o_lposc_clk_en),
    .i_periph_en (o_periph_clk_en),
    .o_main_cnt  (main_cnt),
    .o_core_cnt  (core_cnt),
    .o_out_cnt   (out_cnt),
    .o_lp_cnt    (lp_cnt),
    .o_seen      (seen)
  );
  // Tick tallies jitter by a cycle, so rates get a small tolerance.
  task automatic check(string name, logic [15:0] sv, logic [15:0] ev,
                       int tol);
    checks++;
    if ($isunknown(sv) || sv + tol < ev || sv > ev + tol) begin
      err_count++;
      $display("unexpected %s: expected %0d, seen %0d", name, ev, sv);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge i_core_clk);
  endtask
  // Settles the new selection, then counts over n cycles.
  task automatic measure(int n);
    cyc(3);
    clear = 1'b1;
    cyc(1);
    clear = 1'b0;
    cyc(n);
  endtask
  task automatic cfg(logic [1:0] f, logic [2:0] m, logic [2:0] c,
                     logic [7:0] d, logic [7:0] g);
    cyc(1);
    i_fro_freq_sel = f;
    i_main_sel = m;
    i_clock_output_function_sel = c;
    i_core_div = d;
    i_periph_gate = g;
    i_clk_cfg_wr = 1'b1;
    cyc(1);
    i_clk_cfg_wr = 1'b0;
  endtask
  task automatic enter(logic [1:0] r);
    cyc(1);
    i_mode_enter = 1'b1;
    i_mode_req = r;
    cyc(1);
    i_mode_enter = 1'b0;
  endtask
  task automatic wake(int i);
    i_wake_irq = 6'h01 << i;
    cyc(1);
    check("wake state", o_mode, 3'h4, 0);
    i_wake_irq = 6'h00;
    cyc(1);
    check("wake done", {o_mode, o_wake}, 4'h1, 0);
  endtask
  task automatic row(logic [1:0] f, logic [2:0] m, logic [2:0] c,
                     logic [7:0] d, int em, int ec, int eo);
    cfg(f, m, c, d, 8'hff);
    measure(2500);
    check("main ticks", main_cnt, em, 2);
    check("core ticks", core_cnt, ec, 2);
    check("clock_output_function ticks", out_cnt, eo, 2);
  endtask
  task automatic t_reset();
    measure(2500);
    check("run power", pw, 6'h31, 0);
    check("main ticks", main_cnt, 120, 2);
    check("core ticks", core_cnt, 120, 2);
    check("clock_output_function ticks", out_cnt, 0, 0);
    check("lposc ticks", lp_cnt, 0, 0);
  endtask
  // Every main and output source, the halved rates and divider bounds.
  task automatic t_rates();
    i_lposc_en = 1'b1;
    measure(1000);
    check("lposc ticks", lp_cnt, 4, 2);
    row(2'h1, 3'h0, 3'h0, 8'h01, 150, 150, 150);
    row(2'h0, 3'h1, 3'h3, 8'h02, 60, 30, 60);
    row(2'h2, 3'h0, 3'h1, 8'h03, 90, 30, 10);
    row(2'h2, 3'h1, 3'h7, 8'h00, 45, 45, 0);
    row(2'h3, 3'h3, 3'h2, 8'h01, 10, 10, 125);
    row(2'h1, 3'h1, 3'h3, 8'h01, 75, 75, 75);
    row(2'h3, 3'h2, 3'h0, 8'h01, 125, 125, 120);
    row(2'h0, 3'h7, 3'h3, 8'h01, 0, 0, 0);
  endtask
  task automatic t_sleep();
    cfg(2'h0, 3'h0, 3'h7, 8'h01, 8'h5a);
    measure(500);
    check("gated periph", seen, 8'h5a, 0);
    enter(2'h1);
    check("mode", o_mode, 3'h1, 0);
    measure(500);
    check("sleep core", core_cnt, 0, 0);
    check("sleep main", main_cnt, 24, 2);
    check("sleep periph", seen, 8'h5a, 0);
    i_any_irq = 1'b1;
    cyc(1);
    check("sleep exit", {o_mode, o_wake}, 4'h1, 0);
    i_any_irq = 1'b0;
  endtask
  // A refused write, masked wakes, then every source in turn.
  task automatic t_deep();
    enter(2'h2);
    check("deep power", pw, 6'h28, 0);
    check("deep flash", o_flash_standby, 1'b1, 0);
    measure(200);
    check("deep core", core_cnt, 0, 0);
    check("deep periph", seen, 8'h00, 0);
    cfg(2'h1, 3'h7, 3'h7, 8'h01, 8'h00);
    i_wake_irq = 6'h3f;
    i_irq_en = 6'h3f;
    cyc(4);
    check("masked wake", o_mode, 3'h2, 0);
    i_wake_en = 6'h3f;
    i_irq_en = 6'h00;
    cyc(4);
    check("masked wake", o_mode, 3'h2, 0);
    i_wake_irq = 6'h00;
    i_irq_en = 6'h3f;
    for (int i = 0; i < 6; i++) begin
      enter(2'h2);
      wake(i);
    end
    // Without the keep option the fast oscillator stops in deep-sleep too.
    i_fro_keep_deep = 1'b0;
    enter(2'h2);
    check("deep fro off", pw, 6'h08, 0);
    wake(0);
    measure(500);
    check("restored main", main_cnt, 24, 2);
  endtask
  task automatic t_pdown();
    i_lposc_keep = 1'b1;
    i_bod_keep = 1'b1;
    enter(2'h3);
    check("pdown power", pw, 6'h0f, 0);
    i_any_irq = 1'b1;
    measure(1000);
    check("pdown mode", o_mode, 3'h3, 0);
    check("kept lposc", lp_cnt, 4, 2);
    check("pdown core", core_cnt, 0, 0);
    i_any_irq = 1'b0;
    for (int i = 0; i < 6; i++) begin
      wake(i);
      enter(2'h3);
    end
    wake(0);
    // Dropping the run enable must silence the low-power ticks.
    i_lposc_en = 1'b0;
    measure(500);
    check("lposc off", lp_cnt, 0, 0);
  endtask
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // A hang is cut short well beyond the planned run length.
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      stop_test();
    end
  end
  // Reset for eight cycles, then the scenarios in order.
  initial begin
    cyc(8);
    i_rst = 1'b0;
    t_reset();
    t_rates();
    t_sleep();
    t_deep();
    t_pdown();
    stop_test();
  end
endmodule
